// [rtl/sms_pkg.sv]
// =====================================================
// Register map, control fields and status fields
package sms_pkg;
	// Register byte addresses
	localparam logic [31:0] STATUS_ADDR = 32'hFFFF0A00;
	localparam logic [31:0] RX_ADDR = 32'hFFFF0A04;
	localparam logic [31:0] TX_ADDR = 32'hFFFF0A08;
	localparam logic [31:0] DIV_ADDR = 32'hFFFF0A0C;
	localparam logic [31:0] CTRL_ADDR = 32'hFFFF0A10;

	// Reset values and control write mask
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RX_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h1B;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [12:0] CTRL_MASK = 13'h1FEF;

	// Control field positions
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_MASTER = 1;
	localparam int CTRL_PHASE = 2;
	localparam int CTRL_POLARITY = 3;
	localparam int CTRL_LSB_FIRST = 5;
	localparam int CTRL_TX_START = 6;
	localparam int CTRL_UNDER_ZERO = 7;
	localparam int CTRL_OVERWRITE = 8;
	localparam int CTRL_CS_OUT_EN = 9;
	localparam int CTRL_SLV_OUT_EN = 10;
	localparam int CTRL_LOOPBACK = 11;
	localparam int CTRL_CONTINUOUS = 12;

	// Status field positions
	localparam int ST_TX_BUSY = 0;
	localparam int ST_TX_IRQ = 1;
	localparam int ST_TX_UNDER = 2;
	localparam int ST_RX_FULL = 3;
	localparam int ST_RX_IRQ = 4;
	localparam int ST_RX_OVER = 5;

	// Core clock divide settings at which master mode stops
	localparam logic [2:0] CD_MASTER_LIMIT = 3'h6;

	// Transfer geometry
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	localparam int FIFO_DEPTH = 16;

	// Pin synchroniser lanes
	localparam int PIN_SCLK = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 2;
	localparam int PIN_CS = 3;
	localparam logic [3:0] PIN_RESET = 4'h8;
endpackage : sms_pkg

// [rtl/sms_fifo_if.sv]
`timescale 1ns/1ns
// =====================================================
// Valid/ready stream between the register side and the shifter
interface sms_fifo_if #(parameter int WIDTH = 8);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport user (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
endinterface : sms_fifo_if

// [rtl/sms_fifo.sv]
`timescale 1ns/1ns
// =====================================================
// Synchronous FIFO with honest full and empty
module sms_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	sms_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr;
	logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr;
	logic [AW:0] count_ff, nxt_count;
	logic push;
	logic pop;

	// Handshakes straight from the fill level
	assign port.in_ready = (count_ff != (AW+1)'(DEPTH));
	assign port.out_valid = (count_ff != '0);
	assign port.out_data = mem[rd_ptr_ff];
	assign push = port.in_valid & port.in_ready;
	assign pop = port.out_valid & port.out_ready;

	// Pointer and level update
	always_comb begin
		nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
		nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
		nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff <= nxt_count;
		end
	end

	// Storage has no reset, it is gated by the level
	always_ff @(posedge core_clk_in) begin
		if (push) begin
			mem[wr_ptr_ff] <= port.in_data;
		end
	end
endmodule : sms_fifo

// [rtl/sms_port.sv]
`timescale 1ns/1ns
// =====================================================
// Serial port, master or slave, byte wide, full duplex
module sms_port (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [15:0] bus_wdata_in,
	output logic [15:0] bus_rdata_out,
	input wire logic [2:0] core_clock_divide_field_in,
	output logic tx_ready_out,
	output logic port_irq_out,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_out,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe_out,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe_out,
	input wire logic cs_n_in,
	output logic cs_n_out,
	output logic cs_n_oe_out
);
	typedef enum logic [1:0] {M_IDLE, M_RUN, M_GAP} sms_mst_t;

	// =====================================================
	// State
	logic [15:0] ctrl_ff, nxt_ctrl;
	logic [7:0] div_ff, nxt_div;
	logic [7:0] rxbuf_ff, nxt_rxbuf;
	logic [7:0] last_tx_ff, nxt_last_tx;
	logic [7:0] tx_sh_ff, nxt_tx_sh;
	logic [7:0] rx_sh_ff, nxt_rx_sh;
	logic [2:0] bcnt_ff, nxt_bcnt;
	logic [3:0] ecnt_ff, nxt_ecnt;
	logic [7:0] hcnt_ff, nxt_hcnt;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;
	logic sclk_last_ff, cs_last_ff;
	logic sclk_ff, nxt_sclk;
	logic out_ff, nxt_out;
	logic more_ff, nxt_more;
	logic st1_ff, nxt_st1;
	logic st2_ff, nxt_st2;
	logic st3_ff, nxt_st3;
	logic st4_ff, nxt_st4;
	logic st5_ff, nxt_st5;
	sms_mst_t mst_ff, nxt_mst;

	// Working terms
	logic en, master, cpha, cpol, lsb;
	logic master_ok, slave_on, slv_cs, busy, st0;
	logic wr_tx, rd_rx, wr_div, wr_ctrl;
	logic edge_ev, lead_ev, trail_ev, sample_ev, launch_ev;
	logic start_ev, slv_start, load_ev, byte_done, rx_bit;
	logic [7:0] next_byte, rx_word;
	logic [7:0] status;

	sms_fifo_if #(.WIDTH(8)) txq ();

	sms_fifo #(.WIDTH(8), .DEPTH(sms_pkg::FIFO_DEPTH)) u_txq (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.port(txq.fifo)
	);

	// =====================================================
	// Decode and mode terms
	always_comb begin
		en = ctrl_ff[sms_pkg::CTRL_ENABLE];
		master = ctrl_ff[sms_pkg::CTRL_MASTER];
		cpha = ctrl_ff[sms_pkg::CTRL_PHASE];
		cpol = ctrl_ff[sms_pkg::CTRL_POLARITY];
		lsb = ctrl_ff[sms_pkg::CTRL_LSB_FIRST];
		master_ok = en & master & (core_clock_divide_field_in < sms_pkg::CD_MASTER_LIMIT);
		slave_on = en & ~master;
		slv_cs = slave_on & ~filt_ff[sms_pkg::PIN_CS];
		busy = master ? (mst_ff != M_IDLE) : slv_cs;
		wr_tx = 1'b0;
		rd_rx = 1'b0;
		wr_div = 1'b0;
		wr_ctrl = 1'b0;
		if (bus_wr_in && bus_addr_in == sms_pkg::TX_ADDR) begin
			wr_tx = 1'b1;
		end else if (bus_wr_in && bus_addr_in == sms_pkg::DIV_ADDR) begin
			wr_div = 1'b1;
		end else if (bus_wr_in && bus_addr_in == sms_pkg::CTRL_ADDR) begin
			wr_ctrl = 1'b1;
		end else if (bus_rd_in && bus_addr_in == sms_pkg::RX_ADDR) begin
			rd_rx = 1'b1;
		end
	end

	// =====================================================
	// Edge events from the master divider or the slave pin
	always_comb begin
		// half period is divider+1 core cycles
		edge_ev = (mst_ff == M_RUN) && (hcnt_ff == div_ff);
		if (master) begin
			lead_ev = edge_ev & (sclk_ff == cpol);
			trail_ev = edge_ev & (sclk_ff != cpol);
		end else begin
			lead_ev = slv_cs & (sclk_last_ff == cpol) & (filt_ff[sms_pkg::PIN_SCLK] != cpol);
			trail_ev = slv_cs & (sclk_last_ff != cpol) & (filt_ff[sms_pkg::PIN_SCLK] == cpol);
		end
		// sample on one edge, launch on the other
		sample_ev = cpha ? trail_ev : lead_ev;
		launch_ev = cpha ? lead_ev : trail_ev;
		byte_done = sample_ev & (bcnt_ff == sms_pkg::LAST_BIT);
		if (ctrl_ff[sms_pkg::CTRL_LOOPBACK]) begin
			rx_bit = out_ff;
		end else begin
			rx_bit = master ? filt_ff[sms_pkg::PIN_MISO] : filt_ff[sms_pkg::PIN_MOSI];
		end
		rx_word = lsb ? {rx_bit, rx_sh_ff[7:1]} : {rx_sh_ff[6:0], rx_bit};
		// Underflow sends zero or repeats the last byte
		if (txq.out_valid) begin
			next_byte = txq.out_data;
		end else if (ctrl_ff[sms_pkg::CTRL_UNDER_ZERO]) begin
			next_byte = 8'h00;
		end else begin
			next_byte = last_tx_ff;
		end
	end

	// =====================================================
	// Master sequencer
	always_comb begin
		nxt_mst = mst_ff;
		nxt_hcnt = 8'h00;
		nxt_ecnt = ecnt_ff;
		nxt_sclk = cpol;
		start_ev = 1'b0;
		case (mst_ff)
			M_IDLE: begin
				if (master_ok && (ctrl_ff[sms_pkg::CTRL_TX_START] ? txq.out_valid : rd_rx)) begin
					nxt_mst = M_RUN;
					nxt_ecnt = 4'h0;
					start_ev = 1'b1;
				end
			end
			M_RUN: begin
				nxt_sclk = sclk_ff;
				nxt_hcnt = hcnt_ff + 8'h01;
				if (!master_ok) begin
					nxt_mst = M_IDLE;
					nxt_sclk = cpol;
				end else if (edge_ev) begin
					nxt_sclk = ~sclk_ff;
					nxt_hcnt = 8'h00;
					nxt_ecnt = ecnt_ff + 4'h1;
					// Continue test taken from the queue when the last edge samples, otherwise from more_ff set by the shifter
					if (ecnt_ff == sms_pkg::LAST_EDGE
						&& !(byte_done ? (ctrl_ff[sms_pkg::CTRL_CONTINUOUS] & txq.out_valid) : more_ff)) begin
						nxt_mst = M_GAP;
					end
				end
			end
			M_GAP: begin
				// Stall with select released before next byte
				nxt_hcnt = hcnt_ff + 8'h01;
				if (hcnt_ff == div_ff || !master_ok) begin
					nxt_mst = M_IDLE;
				end
			end
			default: nxt_mst = M_IDLE;
		endcase
	end

	// =====================================================
	// Shift registers and receive buffer
	always_comb begin
		nxt_tx_sh = tx_sh_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_out = out_ff;
		nxt_bcnt = bcnt_ff;
		nxt_more = more_ff;
		nxt_rxbuf = rxbuf_ff;
		nxt_last_tx = last_tx_ff;
		load_ev = 1'b0;
		// select falling starts a slave byte
		slv_start = slave_on & cs_last_ff & ~filt_ff[sms_pkg::PIN_CS];
		if (!slv_cs && !master) begin
			nxt_bcnt = 3'h0;
		end
		// launch and sample run side by side
		if (launch_ev) begin
			nxt_out = lsb ? tx_sh_ff[0] : tx_sh_ff[7];
			nxt_tx_sh = lsb ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0};
		end
		if (sample_ev) begin
			nxt_rx_sh = rx_word;
			nxt_bcnt = bcnt_ff + 3'h1;
		end
		if (byte_done) begin
			if (!st3_ff || rd_rx || ctrl_ff[sms_pkg::CTRL_OVERWRITE]) begin
				nxt_rxbuf = rx_word;
			end
			nxt_more = ctrl_ff[sms_pkg::CTRL_CONTINUOUS] & txq.out_valid;
			if (!master || nxt_more) begin
				load_ev = 1'b1;
				nxt_tx_sh = next_byte;
			end
		end
		if (start_ev || slv_start) begin
			load_ev = 1'b1;
			nxt_bcnt = 3'h0;
			nxt_more = 1'b0;
			// first bit out at once when phase is zero
			if (cpha) begin
				nxt_tx_sh = next_byte;
			end else begin
				nxt_out = lsb ? next_byte[0] : next_byte[7];
				nxt_tx_sh = lsb ? {1'b0, next_byte[7:1]} : {next_byte[6:0], 1'b0};
			end
		end
		if (load_ev && txq.out_valid) begin
			nxt_last_tx = txq.out_data;
		end
	end

	// =====================================================
	// Status flags, set wins over clear except bits 1 and 5, where a transmit write or a receive read wins
	always_comb begin
		st0 = txq.out_valid | busy;
		nxt_st2 = (load_ev & ~txq.out_valid) | (st2_ff & ~wr_tx);
		// transmit interrupt flag
		// A write makes bit 0 true only a cycle later, so it beats the idle set here; disabled port stays quiet
		if (en && !wr_tx && (!st0 || st2_ff)) begin
			nxt_st1 = 1'b1;
		end else if (wr_tx || (!busy && !en)) begin
			nxt_st1 = 1'b0;
		end else begin
			nxt_st1 = st1_ff;
		end
		nxt_st3 = (byte_done & (~st3_ff | rd_rx | ctrl_ff[sms_pkg::CTRL_OVERWRITE]))
			| (st3_ff & ~rd_rx);
		nxt_st5 = (byte_done & st3_ff & ~rd_rx) | (st5_ff & ~rd_rx);
		nxt_st4 = (byte_done & ~rd_rx) | (st4_ff & ~rd_rx);
		if (byte_done && (~st3_ff | rd_rx)) begin
			nxt_st4 = 1'b1;
		end
		status = {2'b00, st5_ff, st4_ff, st3_ff, st2_ff, st1_ff, st0};
	end

	// =====================================================
	// Register writes, read data and pin filter
	always_comb begin
		nxt_div = wr_div ? bus_wdata_in[7:0] : div_ff;
		nxt_ctrl = wr_ctrl ? {3'b000, bus_wdata_in[12:0] & sms_pkg::CTRL_MASK} : ctrl_ff;
		nxt_rdata = 16'h0000;
		if (bus_rd_in && bus_addr_in == sms_pkg::STATUS_ADDR) begin
			nxt_rdata = {8'h00, status};
		end else if (rd_rx) begin
			nxt_rdata = {8'h00, rxbuf_ff};
		end else if (bus_rd_in && bus_addr_in == sms_pkg::DIV_ADDR) begin
			nxt_rdata = {8'h00, div_ff};
		end else if (bus_rd_in && bus_addr_in == sms_pkg::CTRL_ADDR) begin
			nxt_rdata = ctrl_ff;
		end
		// A pin change counts once two stages agree
		nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
		txq.in_valid = wr_tx;
		txq.in_data = bus_wdata_in[7:0];
		txq.out_ready = load_ev;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ctrl_ff <= sms_pkg::CTRL_RESET;
			div_ff <= sms_pkg::DIV_RESET;
			rxbuf_ff <= sms_pkg::RX_RESET;
			last_tx_ff <= 8'h00;
			tx_sh_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			bcnt_ff <= 3'h0;
			ecnt_ff <= 4'h0;
			hcnt_ff <= 8'h00;
			rdata_ff <= 16'h0000;
			s1_ff <= sms_pkg::PIN_RESET;
			s2_ff <= sms_pkg::PIN_RESET;
			s3_ff <= sms_pkg::PIN_RESET;
			filt_ff <= sms_pkg::PIN_RESET;
			sclk_last_ff <= 1'b0;
			cs_last_ff <= 1'b1;
			sclk_ff <= 1'b0;
			out_ff <= 1'b0;
			more_ff <= 1'b0;
			{st5_ff, st4_ff, st3_ff, st2_ff, st1_ff} <= sms_pkg::STATUS_RESET[5:1];
			mst_ff <= M_IDLE;
		end else begin
			ctrl_ff <= nxt_ctrl;
			div_ff <= nxt_div;
			rxbuf_ff <= nxt_rxbuf;
			last_tx_ff <= nxt_last_tx;
			tx_sh_ff <= nxt_tx_sh;
			rx_sh_ff <= nxt_rx_sh;
			bcnt_ff <= nxt_bcnt;
			ecnt_ff <= nxt_ecnt;
			hcnt_ff <= nxt_hcnt;
			rdata_ff <= nxt_rdata;
			s1_ff <= {cs_n_in, miso_in, mosi_in, sclk_in};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= nxt_filt;
			sclk_last_ff <= filt_ff[sms_pkg::PIN_SCLK];
			cs_last_ff <= filt_ff[sms_pkg::PIN_CS];
			sclk_ff <= nxt_sclk;
			out_ff <= nxt_out;
			more_ff <= nxt_more;
			{st5_ff, st4_ff, st3_ff, st2_ff, st1_ff} <= {nxt_st5, nxt_st4, nxt_st3, nxt_st2, nxt_st1};
			mst_ff <= nxt_mst;
		end
	end

	// =====================================================
	// Pins and outputs
	assign bus_rdata_out = rdata_ff;
	assign tx_ready_out = txq.in_ready;
	// one flag picked by control 6
	assign port_irq_out = ctrl_ff[sms_pkg::CTRL_TX_START] ? st1_ff : st4_ff;
	assign sclk_out = sclk_ff;
	// clock pin driven only as master
	assign sclk_oe_out = master_ok;
	assign mosi_out = out_ff;
	// data-out pin driven only as master
	assign mosi_oe_out = master_ok;
	assign miso_out = out_ff;
	// data-in pin driven only as selected slave
	assign miso_oe_out = slv_cs & ctrl_ff[sms_pkg::CTRL_SLV_OUT_EN];
	assign cs_n_out = (mst_ff != M_RUN);
	assign cs_n_oe_out = master_ok & ctrl_ff[sms_pkg::CTRL_CS_OUT_EN];
endmodule : sms_port

// [verif/sms_port_properties.sv]
`timescale 1ns/1ns
// ==========================================
// Port-level checker for the serial port
module sms_port_properties (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [31:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [15:0] bus_wdata_in,
	input wire logic [15:0] bus_rdata_out,
	input wire logic [2:0] core_clock_divide_field_in,
	input wire logic port_irq_out,
	input wire logic sclk_out,
	input wire logic sclk_oe_out,
	input wire logic mosi_oe_out,
	input wire logic miso_oe_out,
	input wire logic cs_n_out
);
	logic sel_ff, nxt_sel_ff, pol_ff, nxt_pol_ff, sclk_q_ff, nxt_sclk_q_ff, wr_ctrl, edge_now;
	logic [11:0] tog_ff, nxt_tog_ff;
	logic [7:0] div_ff, nxt_div_ff, hold_ff, nxt_hold_ff;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Shadow control, divider and edge counters; writes mid-frame are not modelled
	always_comb begin
		wr_ctrl = bus_wr_in && bus_addr_in == sms_pkg::CTRL_ADDR;
		edge_now = sclk_out != sclk_q_ff;
		nxt_sel_ff = wr_ctrl ? bus_wdata_in[sms_pkg::CTRL_TX_START] : sel_ff;
		nxt_pol_ff = wr_ctrl ? bus_wdata_in[sms_pkg::CTRL_POLARITY] : pol_ff;
		nxt_div_ff = (bus_wr_in && bus_addr_in == sms_pkg::DIV_ADDR) ? bus_wdata_in[7:0] : div_ff;
		nxt_sclk_q_ff = sclk_out;
		nxt_tog_ff = cs_n_out ? 12'h000 : tog_ff + {11'h000, edge_now};
		nxt_hold_ff = edge_now ? 8'h00 : hold_ff + 8'h01;
	end
	// Register the helpers
	always_ff @(posedge core_clk_in) begin
		sel_ff <= reset_in ? 1'b0 : nxt_sel_ff;
		pol_ff <= reset_in ? 1'b0 : nxt_pol_ff;
		div_ff <= reset_in ? sms_pkg::DIV_RESET : nxt_div_ff;
		sclk_q_ff <= nxt_sclk_q_ff;
		tog_ff <= reset_in ? 12'h000 : nxt_tog_ff;
		hold_ff <= reset_in ? 8'h00 : nxt_hold_ff;
	end
	sequence status_rd_s;
		bus_rd_in && !bus_wr_in && bus_addr_in == sms_pkg::STATUS_ADDR;
	endsequence
	sequence rx_rd_s;
		bus_rd_in && !bus_wr_in && bus_addr_in == sms_pkg::RX_ADDR && cs_n_out && sclk_oe_out;
	endsequence
	rdata_idle_a: assert property (!bus_rd_in |=> bus_rdata_out == 16'h0000)
		else $error("read data not zero without read");
	oe_exclusive_a: assert property (sclk_oe_out |-> !miso_oe_out)
		else $error("data-in pin driven in master mode");
	mosi_oe_a: assert property (mosi_oe_out == sclk_oe_out)
		else $error("data-out enable differs from clock enable");
	master_limit_a: assert property ((core_clock_divide_field_in >= sms_pkg::CD_MASTER_LIMIT) [*2] |-> !sclk_oe_out)
		else $error("master active at high core divide");
	byte_edges_a: assert property ($rose(cs_n_out) |-> edge_now && tog_ff[3:0] == 4'hF)
		else $error("frame clock edges not a multiple of sixteen");
	clock_rate_a: assert property (!cs_n_out && edge_now && tog_ff != 12'h000 |-> hold_ff == div_ff)
		else $error("serial clock half period wrong");
	sclk_idle_a: assert property ((cs_n_out && !bus_wr_in) [*3] |-> sclk_out == pol_ff)
		else $error("serial clock idle level wrong");
	irq_source_a: assert property (status_rd_s |=> bus_rdata_out[$past(sel_ff) ? 1 : 4] == $past(port_irq_out))
		else $error("interrupt does not follow selected status bit");
	rx_irq_follow_a: assert property (status_rd_s |=> !(bus_rdata_out[3] || bus_rdata_out[5]) || bus_rdata_out[4])
		else $error("receive interrupt flag missing");
	rx_read_clear_a: assert property (rx_rd_s ##1 (cs_n_out && sclk_oe_out) ##1 status_rd_s |=> bus_rdata_out[5:3] == 3'h0)
		else $error("receive flags not cleared by read");
endmodule : sms_port_properties

bind sms_port sms_port_properties u_props (.core_clk_in(core_clk_in), .reset_in(reset_in),
	.bus_addr_in(bus_addr_in), .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_wdata_in(bus_wdata_in),
	.bus_rdata_out(bus_rdata_out), .core_clock_divide_field_in(core_clock_divide_field_in),
	.port_irq_out(port_irq_out), .sclk_out(sclk_out), .sclk_oe_out(sclk_oe_out), .mosi_oe_out(mosi_oe_out),
	.miso_oe_out(miso_oe_out), .cs_n_out(cs_n_out));

// [verif/sms_slave_model.sv]
`timescale 1ns/1ns
// ==========================================
// External slave, idle-low clock, sample on leading edge
module sms_slave_model (
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic mosi_in,
	input wire logic [7:0] reply_in,
	output logic miso_out,
	output logic [7:0] got_out,
	output int edges_out
);
	logic [7:0] shift_q;
	initial miso_out = 1'b0;
	always @(negedge cs_n_in) begin
		shift_q = reply_in;
		miso_out = reply_in[7];
		edges_out = 0;
	end
	always @(posedge sclk_in) if (!cs_n_in) begin
		got_out = {got_out[6:0], mosi_in};
		edges_out++;
	end
	always @(negedge sclk_in) if (!cs_n_in) begin
		shift_q = shift_q << 1;
		miso_out = shift_q[7];
	end
	// Released line must not look like valid data
	always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule : sms_slave_model

// [verif/sms_port_tb.sv]
`timescale 1ns/1ns
// ==========================================
// Self-checking bench, port as master
module sms_port_tb;
	logic core_clk_in = 1'b0, reset_in = 1'b1, bus_wr_in = 1'b0, bus_rd_in = 1'b0;
	logic [31:0] bus_addr_in = 32'h0;
	logic [15:0] bus_wdata_in = 16'h0, bus_rdata_out, d;
	logic [2:0] core_clock_divide_field_in = 3'h0;
	logic [7:0] reply = 8'h00, got;
	logic port_irq_out, sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, cs_n_out, cs_n_oe_out;
	logic slave_miso;
	int edges, bad_count = 0, checks = 0;
	// Pin levels: clock and data-out pulled down, select pulled up, data-in from the slave model
	wire sclk_pin = sclk_oe_out ? sclk_out : 1'b0;
	wire mosi_pin = mosi_oe_out ? mosi_out : 1'b0;
	wire cs_pin = cs_n_oe_out ? cs_n_out : 1'b1;
	wire miso_pin = miso_oe_out ? miso_out : slave_miso;
	sms_port u_dut (.core_clk_in, .reset_in, .bus_addr_in, .bus_wr_in, .bus_rd_in, .bus_wdata_in, .bus_rdata_out,
		.core_clock_divide_field_in, .tx_ready_out(), .port_irq_out, .sclk_in(sclk_pin), .sclk_out, .sclk_oe_out,
		.mosi_in(mosi_pin), .mosi_out, .mosi_oe_out, .miso_in(miso_pin), .miso_out, .miso_oe_out,
		.cs_n_in(cs_pin), .cs_n_out, .cs_n_oe_out);
	sms_slave_model u_slave (.sclk_in(sclk_pin), .cs_n_in(cs_pin), .mosi_in(mosi_pin), .reply_in(reply),
		.miso_out(slave_miso), .got_out(got), .edges_out(edges));
	// 10 MHz clock
	initial forever #50 core_clk_in = ~core_clk_in;
	// ==========================================
	// Shared tasks
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [15:0] v);
		@(posedge core_clk_in);
		bus_addr_in <= a;
		bus_wdata_in <= v;
		bus_wr_in <= 1'b1;
		@(posedge core_clk_in);
		bus_wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a);
		@(posedge core_clk_in);
		bus_addr_in <= a;
		bus_rd_in <= 1'b1;
		@(posedge core_clk_in);
		bus_rd_in <= 1'b0;
		#1 d = bus_rdata_out;
	endtask : rd
	// Bounded wait for one whole frame on the select pin
	task automatic wait_byte();
		int n;
		n = 0;
		while (cs_pin && n < 60) begin @(posedge core_clk_in); n++; end
		chk("frame start", 16'h0000, {15'h0, cs_pin});
		while (!cs_pin && n < 400) begin @(posedge core_clk_in); n++; end
		chk("clock edges", 16'h0008, edges[15:0]);
		repeat (12) @(posedge core_clk_in);
	endtask : wait_byte
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
	endfunction : rev
	task automatic summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : summarize
	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] a[5] = '{sms_pkg::STATUS_ADDR, sms_pkg::RX_ADDR, sms_pkg::DIV_ADDR, sms_pkg::CTRL_ADDR,
			32'hFFFF0A14};
		logic [15:0] e[5] = '{16'h0000, 16'h0000, {8'h00, sms_pkg::DIV_RESET}, sms_pkg::CTRL_RESET, 16'h0000};
		foreach (a[i]) begin rd(a[i]); chk("reset value", e[i], d); end
		wr(sms_pkg::STATUS_ADDR, 16'h00FF);
		rd(sms_pkg::STATUS_ADDR);
		chk("status read only", 16'h0000, d);
		$display("test reset done");
	endtask : t_reset
	task automatic t_master();
		wr(sms_pkg::DIV_ADDR, 16'h0005);
		wr(sms_pkg::CTRL_ADDR, 16'h0243);
		reply = 8'h3C;
		wr(sms_pkg::TX_ADDR, 16'h00A5);
		wait_byte();
		chk("sent byte", 16'h00A5, {8'h00, got});
		chk("pin dirs", 16'h0001, {15'h0, sclk_oe_out && mosi_oe_out && !miso_oe_out});
		rd(sms_pkg::STATUS_ADDR);
		chk("status full", 16'h001A, d);
		chk("tx irq", 16'h0001, {15'h0, port_irq_out});
		rd(sms_pkg::RX_ADDR);
		chk("received byte", 16'h003C, d);
		rd(sms_pkg::STATUS_ADDR);
		chk("status read", 16'h0002, d);
		$display("test master done");
	endtask : t_master
	task automatic t_lsb();
		wr(sms_pkg::CTRL_ADDR, 16'h0263);
		reply = 8'hC4;
		wr(sms_pkg::TX_ADDR, 16'h0012);
		wait_byte();
		chk("lsb sent", {8'h00, rev(8'h12)}, {8'h00, got});
		rd(sms_pkg::RX_ADDR);
		chk("lsb received", {8'h00, rev(8'hC4)}, d);
		$display("test lsb done");
	endtask : t_lsb
	task automatic t_overflow();
		wr(sms_pkg::CTRL_ADDR, 16'h0243);
		reply = 8'h11;
		wr(sms_pkg::TX_ADDR, 16'h0055);
		wait_byte();
		reply = 8'h22;
		wr(sms_pkg::TX_ADDR, 16'h0066);
		wait_byte();
		rd(sms_pkg::STATUS_ADDR);
		chk("overflow flags", 16'h0038, d & 16'h0038);
		rd(sms_pkg::RX_ADDR);
		chk("drop keeps old", 16'h0011, d);
		rd(sms_pkg::STATUS_ADDR);
		chk("overflow cleared", 16'h0000, d & 16'h0038);
		wr(sms_pkg::CTRL_ADDR, 16'h0343);
		wr(sms_pkg::TX_ADDR, 16'h0033);
		wait_byte();
		reply = 8'h44;
		wr(sms_pkg::TX_ADDR, 16'h0077);
		wait_byte();
		rd(sms_pkg::RX_ADDR);
		chk("overwrite new", 16'h0044, d);
		$display("test overflow done");
	endtask : t_overflow
	task automatic t_loop();
		wr(sms_pkg::CTRL_ADDR, 16'h0A43);
		wr(sms_pkg::TX_ADDR, 16'h005E);
		wait_byte();
		rd(sms_pkg::RX_ADDR);
		chk("loopback byte", 16'h005E, d);
		$display("test loopback done");
	endtask : t_loop
	task automatic t_rx_start();
		wr(sms_pkg::CTRL_ADDR, 16'h0283);
		reply = 8'h5A;
		rd(sms_pkg::RX_ADDR);
		wait_byte();
		chk("zero on underflow", 16'h0000, {8'h00, got});
		rd(sms_pkg::STATUS_ADDR);
		chk("rx start status", 16'h001C, d & 16'h001C);
		chk("rx irq", 16'h0001, {15'h0, port_irq_out});
		wr(sms_pkg::TX_ADDR, 16'h0077);
		rd(sms_pkg::STATUS_ADDR);
		chk("underflow cleared", 16'h0000, d & 16'h0004);
		$display("test rx start done");
	endtask : t_rx_start
	task automatic t_polarity();
		wr(sms_pkg::CTRL_ADDR, 16'h000B);
		repeat (4) @(posedge core_clk_in);
		chk("idle high", 16'h0001, {15'h0, sclk_out});
		wr(sms_pkg::CTRL_ADDR, 16'h0003);
		repeat (4) @(posedge core_clk_in);
		chk("idle low", 16'h0000, {15'h0, sclk_out});
		$display("test polarity done");
	endtask : t_polarity
	task automatic t_cd_limit();
		@(posedge core_clk_in);
		core_clock_divide_field_in <= 3'h6;
		wr(sms_pkg::CTRL_ADDR, 16'h0243);
		wr(sms_pkg::TX_ADDR, 16'h0099);
		repeat (40) @(posedge core_clk_in);
		chk("no master frame", 16'h0001, {15'h0, cs_pin && !sclk_oe_out});
		@(posedge core_clk_in);
		core_clock_divide_field_in <= 3'h0;
		wait_byte();
		chk("held byte", 16'h0077, {8'h00, got});
		$display("test core divide done");
	endtask : t_cd_limit
	// Cut a hang short
	initial begin
		repeat (20000) @(posedge core_clk_in);
		bad_count++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk_in);
		reset_in <= 1'b0;
		t_reset();
		t_master();
		t_lsb();
		t_overflow();
		t_loop();
		t_rx_start();
		t_polarity();
		t_cd_limit();
		summarize();
	end
endmodule : sms_port_tb
